// file: logic/ata_tf_pkg.sv
// Purpose: Shared constants of the task file register bank
// Assumes: Byte registers of 8 bits, data port of 16 bits
// Notes:   Offsets are the four low address lines of the host bus
package ata_tf_pkg;

  // Register offsets
  localparam logic [3:0] OFF_DATA       = 4'h0;
  localparam logic [3:0] OFF_FAILURE    = 4'h1;
  localparam logic [3:0] OFF_COUNT      = 4'h2;
  localparam logic [3:0] OFF_SECTOR     = 4'h3;
  localparam logic [3:0] OFF_CYL_MID    = 4'h4;
  localparam logic [3:0] OFF_CYL_HIGH   = 4'h5;
  localparam logic [3:0] OFF_DRIVE_HEAD = 4'h6;
  localparam logic [3:0] OFF_DUP_EVEN   = 4'h8;
  localparam logic [3:0] OFF_DUP_ODD    = 4'h9;
  localparam logic [3:0] OFF_DUP_FAIL   = 4'hD;

  // Failure cause field positions
  localparam int BAD_BLOCK_FLAG_BIT      = 7;
  localparam int UNCORRECTABLE_FLAG_BIT  = 6;
  localparam int SECTOR_ID_MISSING_BIT   = 4;
  localparam int COMMAND_ABORTED_BIT_POS = 2;
  localparam int GENERAL_ERROR_FLAG_BIT  = 0;

  // Drive/head field positions and fixed ones
  localparam int         LBA_MODE_BIT      = 6;
  localparam int         DRIVE_NUMBER_BIT  = 4;
  localparam logic [7:0] DRIVE_HEAD_ONES   = 8'hA0;

  // Reset values
  localparam logic [7:0]  RST_BYTE         = 8'h00;
  localparam logic [7:0]  RST_DRIVE_HEAD   = 8'hA0;
  localparam logic [15:0] RST_WORD         = 16'h0000;

  // A programmed count of zero means this many sectors
  localparam logic [8:0]  COUNT_ZERO_MEANS = 9'h100;

  // Idle level of the synchronised pin vector: strobes and enables high
  localparam int          PIN_W            = 25;
  localparam logic [24:0] PIN_IDLE         = 25'h0F00000;

endpackage

// file: logic/ata_sector_buffer.sv
// Purpose: Word buffer between host data port and card controller
// Assumes: One write and one read per port per cycle
// Notes:   Read data come out of a register one cycle after the address
`timescale 1ns/1ns
module ata_sector_buffer #(
  parameter int AW = 8,
  parameter int DW = 16
) (
  input  wire logic          clk,
  input  wire logic          arst_n,
  input  wire logic          a_we,
  input  wire logic [AW-1:0] a_addr,
  input  wire logic [DW-1:0] a_wdata,
  output logic      [DW-1:0] a_rdata,
  input  wire logic          b_we,
  input  wire logic [AW-1:0] b_addr,
  input  wire logic [DW-1:0] b_wdata,
  output logic      [DW-1:0] b_rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Storage; the controller wins a same-word collision since it owns the sector
  always_ff @(posedge clk) begin
    if (b_we) begin
      mem[b_addr] <= b_wdata;
    end
    if (a_we && !(b_we && (a_addr == b_addr))) begin
      mem[a_addr] <= a_wdata;
    end
  end

  // Registered read ports
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      a_rdata <= '0;
      b_rdata <= '0;
    end else begin
      a_rdata <= mem[a_addr];
      b_rdata <= mem[b_addr];
    end
  end

endmodule

// file: logic/ata_task_file_registers.sv
// Purpose: Task file registers and data port of a removable storage card
// Assumes: Host strobes are slow against CLK; all bus pins are synchronised
// Notes:   Status, device control and command registers live elsewhere
//
// What this block does
// - Odd registers also answer high lane, even address, unless narrow I/O
// - Sixteen-bit data port to the card buffer
// - Word access at offset one hits data
// - Duplicates at 8, 9, Dh take all accesses
// - Failure cause holds detail when status errs
// - Bit seven bad block, bit six uncorrectable
// - Bit four sector id, bit zero general
// - Bit two marks an aborted command
// - Failure cause readable on high lane at zero, unless narrow I/O
// - Failure cause read only, feature write only
// - Feature high-lane write at zero, not IDE mode
// - Sector count zero means 256 sectors
// - Count ends zero, or sectors still left
// - Offset three: start sector or address 7-0
// - Cylinder bytes or address bits 15-8, 23-16
// - Drive/head bits seven and five read one
// - Drive/head bit six selects logical addressing
// - Build 28-bit logical block address
// - Drive/head bit four selects drive number
// - Socket mode takes drive from copy field
// - Low four bits: head or address 27-24
// - Status error bit set on failed command
// - Repeated accesses step through buffer sequentially
`timescale 1ns/1ns
module ata_task_file_registers
  import ata_tf_pkg::*;
#(
  parameter int BUF_AW = 8
) (
  input  wire logic              CLK,
  input  wire logic              ARST_N,
  input  wire logic [3:0]        ADDR,
  input  wire logic              LOW_BYTE_ENABLE_N,
  input  wire logic              HIGH_BYTE_ENABLE_N,
  input  wire logic              RD_N,
  input  wire logic              WR_N,
  input  wire logic              IO_CYCLE,
  input  wire logic [15:0]       D_IN,
  output logic      [15:0]       D_OUT,
  output logic                   D_OE,
  input  wire logic              IO_WIDE_INDICATE_N,
  input  wire logic              IDE_MODE,
  input  wire logic              SOCKET_MODE,
  input  wire logic              COPY_DRIVE,
  input  wire logic              CMD_START,
  input  wire logic              ERR_LOAD,
  input  wire logic              ERR_BAD_BLOCK,
  input  wire logic              ERR_UNCORRECTABLE,
  input  wire logic              ERR_ID_MISSING,
  input  wire logic              ERR_ABORTED,
  input  wire logic              ERR_GENERAL,
  input  wire logic              COUNT_DEC,
  input  wire logic              BUF_PTR_CLR,
  input  wire logic              CTRL_WE,
  input  wire logic [BUF_AW-1:0] CTRL_ADDR,
  input  wire logic [15:0]       CTRL_WDATA,
  output logic      [15:0]       CTRL_RDATA,
  output logic      [7:0]        FEATURE,
  output logic      [7:0]        FAILURE_CAUSE,
  output logic      [8:0]        SECTORS_REQ,
  output logic                   LBA_MODE,
  output logic      [27:0]       LBA_ADDR,
  output logic      [3:0]        HEAD_NUM,
  output logic                   DRIVE_SEL,
  output logic                   STATUS_ERR
);

  import ata_tf_pkg::*;

  logic [PIN_W-1:0]  pin_s1_r;
  logic [PIN_W-1:0]  pin_s2_r;
  logic              rd_n_prev_r;
  logic              wr_n_prev_r;
  logic              io_s;
  logic              rd_n_s;
  logic              wr_n_s;
  logic              he_n_s;
  logic              le_n_s;
  logic [3:0]        a_s;
  logic [15:0]       din_s;
  logic              rd_go;
  logic              wr_go;
  logic              acc_go;
  logic              word_acc;
  logic              byte_lo;
  logic              byte_hi;
  logic              data_word;
  logic              data_even;
  logic              data_odd;
  logic              lo_hit;
  logic              hi_hit;
  logic [3:0]        lo_idx;
  logic [3:0]        hi_idx;
  logic [7:0]        count_r;
  logic [7:0]        sector_r;
  logic [7:0]        cyl_mid_r;
  logic [7:0]        cyl_high_r;
  logic [7:0]        drive_head_r;
  logic [BUF_AW-1:0] ptr_r;
  logic              odd_phase_r;
  logic [7:0]        even_hold_r;
  logic              host_buf_we;
  logic [15:0]       host_buf_wdata;
  logic [15:0]       host_buf_rdata;
  logic [7:0]        odd_wbyte;
  logic [7:0]        fail_nxt;

  // Two flip-flops on every bus pin before any logic looks at it
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pin_s1_r <= PIN_IDLE;
      pin_s2_r <= PIN_IDLE;
    end else begin
      pin_s1_r <= {IO_CYCLE, RD_N, WR_N, HIGH_BYTE_ENABLE_N, LOW_BYTE_ENABLE_N, ADDR, D_IN};
      pin_s2_r <= pin_s1_r;
    end
  end

  assign {io_s, rd_n_s, wr_n_s, he_n_s, le_n_s, a_s, din_s} = pin_s2_r;

  // Strobe history for start-of-access detection
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rd_n_prev_r <= 1'b1;
      wr_n_prev_r <= 1'b1;
    end else begin
      rd_n_prev_r <= rd_n_s;
      wr_n_prev_r <= wr_n_s;
    end
  end

  // One access per strobe; the bus pins settle before the strobe falls
  assign rd_go  = !rd_n_s && rd_n_prev_r;
  assign wr_go  = !wr_n_s && wr_n_prev_r;
  assign acc_go = rd_go || wr_go;

  // Byte register contents as the host sees them on one lane
  function automatic logic [7:0] reg_byte(input logic [3:0] idx, input logic [7:0] fail,
                                          input logic [7:0] cnt, input logic [7:0] sec,
                                          input logic [7:0] cmid, input logic [7:0] chigh,
                                          input logic [7:0] dh);
    logic [7:0] v;
    v = 8'h00;
    unique case (idx)
      OFF_FAILURE, OFF_DUP_FAIL: v = fail;
      OFF_COUNT:                 v = cnt;
      OFF_SECTOR:                v = sec;
      OFF_CYL_MID:               v = cmid;
      OFF_CYL_HIGH:              v = chigh;
      OFF_DRIVE_HEAD:            v = dh | DRIVE_HEAD_ONES;
      default:                   v = 8'h00;
    endcase
    return v;
  endfunction

  // Lane and path decode of the current access
  always_comb begin
    word_acc  = !le_n_s && !he_n_s;
    byte_lo   = !le_n_s && he_n_s;
    byte_hi   = le_n_s && !he_n_s;
    // Word at 1 goes to the data port, not to the failure/feature pair
    data_word = word_acc && (a_s == OFF_DATA || a_s == OFF_FAILURE ||
                             a_s == OFF_DUP_EVEN || a_s == OFF_DUP_ODD);
    data_even = byte_lo && (a_s == OFF_DATA || a_s == OFF_DUP_EVEN);
    data_odd  = (byte_lo && a_s == OFF_DUP_ODD) ||
                (byte_hi && (a_s == OFF_DUP_EVEN || a_s == OFF_DUP_ODD));
    lo_idx    = byte_lo ? a_s : {a_s[3:1], 1'b0};
    hi_idx    = {a_s[3:1], 1'b1};
    lo_hit    = (byte_lo && !data_even && !data_odd) || (word_acc && !data_word);
    // Odd register on the high lane at the even address, unless narrow I/O
    hi_hit    = ((byte_hi && !data_odd) || (word_acc && !data_word)) &&
                !(byte_hi && io_s && IO_WIDE_INDICATE_N);
  end

  // Write hit on one lane for one register offset
  function automatic logic lane_wr(input logic go, input logic hit,
                                   input logic [3:0] idx, input logic [3:0] off);
    return go && hit && (idx == off);
  endfunction

  // Sector count: host loads it, the controller counts down per sector moved
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      count_r <= RST_BYTE;
    end else if (lane_wr(wr_go, lo_hit, lo_idx, OFF_COUNT)) begin
      count_r <= din_s[7:0];
    end else if (COUNT_DEC && count_r != 8'h00) begin
      count_r <= count_r - 8'h01;
    end
  end

  // Address registers; sector and cylinder high on either lane, cylinder mid on the low lane only
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sector_r   <= RST_BYTE;
      cyl_mid_r  <= RST_BYTE;
      cyl_high_r <= RST_BYTE;
    end else begin
      if (lane_wr(wr_go, hi_hit, hi_idx, OFF_SECTOR)) begin
        sector_r <= din_s[15:8];
      end else if (lane_wr(wr_go, lo_hit, lo_idx, OFF_SECTOR)) begin
        sector_r <= din_s[7:0];
      end
      if (lane_wr(wr_go, lo_hit, lo_idx, OFF_CYL_MID)) begin
        cyl_mid_r <= din_s[7:0];
      end
      if (lane_wr(wr_go, hi_hit, hi_idx, OFF_CYL_HIGH)) begin
        cyl_high_r <= din_s[15:8];
      end else if (lane_wr(wr_go, lo_hit, lo_idx, OFF_CYL_HIGH)) begin
        cyl_high_r <= din_s[7:0];
      end
    end
  end

  // Drive/head keeps its fixed ones stored so every reader sees them
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      drive_head_r <= RST_DRIVE_HEAD;
    end else if (lane_wr(wr_go, lo_hit, lo_idx, OFF_DRIVE_HEAD)) begin
      drive_head_r <= din_s[7:0] | DRIVE_HEAD_ONES;
    end
  end

  // Feature is write only; the high lane at offset zero is off in IDE mode
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      FEATURE <= RST_BYTE;
    end else if (lane_wr(wr_go, lo_hit, lo_idx, OFF_FAILURE) ||
                 lane_wr(wr_go, lo_hit, lo_idx, OFF_DUP_FAIL)) begin
      FEATURE <= din_s[7:0];
    end else if ((lane_wr(wr_go, hi_hit, hi_idx, OFF_FAILURE) && !IDE_MODE) ||
                 lane_wr(wr_go, hi_hit, hi_idx, OFF_DUP_FAIL)) begin
      FEATURE <= din_s[15:8];
    end
  end

  // Failure cause image; reserved bits stay zero
  always_comb begin
    fail_nxt = 8'h00;
    fail_nxt[BAD_BLOCK_FLAG_BIT]      = ERR_BAD_BLOCK;
    fail_nxt[UNCORRECTABLE_FLAG_BIT]  = ERR_UNCORRECTABLE;
    fail_nxt[SECTOR_ID_MISSING_BIT]   = ERR_ID_MISSING;
    fail_nxt[COMMAND_ABORTED_BIT_POS] = ERR_ABORTED;
    fail_nxt[GENERAL_ERROR_FLAG_BIT]  = ERR_GENERAL;
  end

  // Cause and status error flag; a load in the clearing cycle wins
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      FAILURE_CAUSE <= RST_BYTE;
      STATUS_ERR    <= 1'b0;
    end else if (ERR_LOAD) begin
      FAILURE_CAUSE <= fail_nxt;
      STATUS_ERR    <= (fail_nxt != 8'h00);
    end else if (CMD_START) begin
      FAILURE_CAUSE <= RST_BYTE;
      STATUS_ERR    <= 1'b0;
    end
  end

  // Byte written into the odd half, from whichever lane carried it
  assign odd_wbyte = byte_lo ? din_s[7:0] : din_s[15:8];

  // Buffer write data for host writes through the data port
  always_comb begin
    host_buf_we    = 1'b0;
    host_buf_wdata = din_s;
    if (wr_go && data_word) begin
      host_buf_we = 1'b1;
    end else if (wr_go && data_even && odd_phase_r) begin
      host_buf_we    = 1'b1;
      host_buf_wdata = {din_s[7:0], even_hold_r};
    end else if (wr_go && data_odd) begin
      host_buf_we    = 1'b1;
      host_buf_wdata = {odd_wbyte, even_hold_r};
    end
  end

  // Sequential stepping: words advance, even-byte accesses go even then odd
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ptr_r       <= '0;
      odd_phase_r <= 1'b0;
      even_hold_r <= RST_BYTE;
    end else if (BUF_PTR_CLR) begin
      ptr_r       <= '0;
      odd_phase_r <= 1'b0;
    end else if (acc_go && (data_word || data_odd)) begin
      ptr_r       <= ptr_r + 1'b1;
      odd_phase_r <= 1'b0;
    end else if (acc_go && data_even) begin
      // Repeating odd-byte accesses would skip even bytes; even-byte accesses alternate
      if (odd_phase_r) begin
        ptr_r <= ptr_r + 1'b1;
      end else if (wr_go) begin
        even_hold_r <= din_s[7:0];
      end
      odd_phase_r <= !odd_phase_r;
    end
  end

  ata_sector_buffer #(
    .AW (BUF_AW),
    .DW (16)
  ) u_buf (
    .clk     (CLK),
    .arst_n  (ARST_N),
    .a_we    (host_buf_we),
    .a_addr  (ptr_r),
    .a_wdata (host_buf_wdata),
    .a_rdata (host_buf_rdata),
    .b_we    (CTRL_WE),
    .b_addr  (CTRL_ADDR),
    .b_wdata (CTRL_WDATA),
    .b_rdata (CTRL_RDATA)
  );

  // Read answer is latched at the strobe and held until it rises
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      D_OUT <= RST_WORD;
      D_OE  <= 1'b0;
    end else if (rd_go) begin
      D_OE <= 1'b1;
      if (data_word) begin
        D_OUT <= host_buf_rdata;
      end else if (data_even) begin
        D_OUT <= {8'h00, odd_phase_r ? host_buf_rdata[15:8] : host_buf_rdata[7:0]};
      end else if (data_odd) begin
        D_OUT <= byte_lo ? {8'h00, host_buf_rdata[15:8]} : {host_buf_rdata[15:8], 8'h00};
      end else begin
        D_OUT[7:0]  <= lo_hit ? reg_byte(lo_idx, FAILURE_CAUSE, count_r, sector_r,
                                         cyl_mid_r, cyl_high_r, drive_head_r) : 8'h00;
        D_OUT[15:8] <= hi_hit ? reg_byte(hi_idx, FAILURE_CAUSE, count_r, sector_r,
                                         cyl_mid_r, cyl_high_r, drive_head_r) : 8'h00;
      end
    end else if (rd_n_s) begin
      D_OE <= 1'b0;
    end
  end

  // Addressing outputs for the card controller
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      LBA_MODE    <= 1'b0;
      LBA_ADDR    <= '0;
      HEAD_NUM    <= 4'h0;
      DRIVE_SEL   <= 1'b0;
      SECTORS_REQ <= COUNT_ZERO_MEANS;
    end else begin
      LBA_MODE    <= drive_head_r[LBA_MODE_BIT];
      LBA_ADDR    <= {drive_head_r[3:0], cyl_high_r, cyl_mid_r, sector_r};
      HEAD_NUM    <= drive_head_r[3:0];
      DRIVE_SEL   <= SOCKET_MODE ? COPY_DRIVE
                                 : drive_head_r[DRIVE_NUMBER_BIT];
      SECTORS_REQ <= (count_r == 8'h00) ? COUNT_ZERO_MEANS : {1'b0, count_r};
    end
  end

endmodule

// file: tb/ata_tf_regs_sva.sv
// Purpose: Port-level checks of the task file register bank
// Assumes: Bound to the top module; host strobes spaced as the bus allows
// Notes:   Registered outputs get up to two edges to follow their cause, D_OE up to five
`timescale 1ns/1ns
module ata_tf_regs_sva (
  input wire logic       CLK,
  input wire logic       ARST_N,
  input wire logic       RD_N,
  input wire logic       D_OE,
  input wire logic       SOCKET_MODE,
  input wire logic       COPY_DRIVE,
  input wire logic       DRIVE_SEL,
  input wire logic       CMD_START,
  input wire logic       ERR_LOAD,
  input wire logic       ERR_BAD_BLOCK,
  input wire logic       ERR_UNCORRECTABLE,
  input wire logic       ERR_ID_MISSING,
  input wire logic       ERR_ABORTED,
  input wire logic       ERR_GENERAL,
  input wire logic [7:0] FAILURE_CAUSE,
  input wire logic [8:0] SECTORS_REQ,
  input wire logic       STATUS_ERR
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);
  // Cause as the loaded flags should leave it, reserved bits zero
  logic [7:0] cause_exp;
  assign cause_exp = {ERR_BAD_BLOCK, ERR_UNCORRECTABLE, 1'b0, ERR_ID_MISSING, 1'b0,
                      ERR_ABORTED, 1'b0, ERR_GENERAL};
  chk_cause_zeros: assert property ((FAILURE_CAUSE & 8'h2A) == 8'h00)
    else $error("reserved cause bit set");
  chk_count_wrap: assert property (SECTORS_REQ[8] |-> SECTORS_REQ[7:0] == 8'h00)
    else $error("sector count beyond 256");
  chk_cause_load: assert property (ERR_LOAD |-> ##[1:2] FAILURE_CAUSE == cause_exp)
    else $error("cause not loaded");
  chk_status_set: assert property (ERR_LOAD && ERR_GENERAL |-> ##[1:2] STATUS_ERR)
    else $error("status error not set");
  chk_start_clear: assert property (
    CMD_START && !ERR_LOAD |-> ##[1:2] !STATUS_ERR && FAILURE_CAUSE == 8'h00)
    else $error("cause not cleared at command start");
  chk_read_drive: assert property ($fell(RD_N) |-> ##[2:5] D_OE)
    else $error("read data not driven");
  chk_read_release: assert property ($rose(RD_N) |-> ##[1:5] !D_OE)
    else $error("data bus not released");
  // Both one and two edges of latency pass, as the inputs are held steady
  chk_drive_copy: assert property (
    $past(SOCKET_MODE, 2) && $past(SOCKET_MODE) && $past(COPY_DRIVE, 2) == $past(COPY_DRIVE)
    |-> DRIVE_SEL == $past(COPY_DRIVE)) else $error("drive number not from copy field");
endmodule

// file: tb/ata_host_model.sv
// Purpose: Host side of the parallel task file bus
// Assumes: One access at a time, spaced well apart
// Notes:   Released data lines are inverted so stale values never match
`timescale 1ns/1ns
module ata_host_model (
  input  wire logic        CLK,
  input  wire logic [15:0] D_OUT,
  output logic      [3:0]  ADDR,
  output logic             LOW_BYTE_ENABLE_N,
  output logic             HIGH_BYTE_ENABLE_N,
  output logic             RD_N,
  output logic             WR_N,
  output logic             IO_CYCLE,
  output logic      [15:0] D_IN
);
  logic io_sel = 1'b0;
  // Idle bus: strobes and lane enables high
  initial begin
    {ADDR, IO_CYCLE, D_IN} = 21'h000000;
    {LOW_BYTE_ENABLE_N, HIGH_BYTE_ENABLE_N, RD_N, WR_N} = 4'hF;
  end
  // Qualifiers settle two edges before the strobe and hold past its rise;
  // callers may repeat odd-byte data accesses, each one stepping on to the next word
  task automatic acc(input bit wr, input logic [3:0] a, input logic le_n,
                     input logic he_n, input logic [15:0] wd, output logic [15:0] rd);
    @(posedge CLK);
    #2 {ADDR, LOW_BYTE_ENABLE_N, HIGH_BYTE_ENABLE_N, IO_CYCLE} = {a, le_n, he_n, io_sel};
    D_IN = wr ? wd : ~D_IN;
    repeat (2) @(posedge CLK);
    #2 {RD_N, WR_N} = wr ? 2'h2 : 2'h1;
    repeat (6) @(posedge CLK);
    rd = D_OUT;
    #2 {RD_N, WR_N} = 2'h3;
    repeat (5) @(posedge CLK);
    #2 D_IN = ~D_IN;
    {LOW_BYTE_ENABLE_N, HIGH_BYTE_ENABLE_N} = 2'h3;
  endtask
endmodule

// file: tb/test_ata_task_file_registers.sv
// Purpose: Self-checking bench of the task file register bank
// Assumes: Host cycles come from the host model, controller side from here
// Notes:   Expected values come from the small model below
`timescale 1ns/1ns
module test_ata_task_file_registers;
  import ata_tf_pkg::*;
  logic        CLK, ARST_N, IO_WIDE_INDICATE_N, IDE_MODE, SOCKET_MODE, COPY_DRIVE;
  logic        CMD_START, ERR_LOAD, ERR_BAD_BLOCK, ERR_UNCORRECTABLE, ERR_ID_MISSING;
  logic        ERR_ABORTED, ERR_GENERAL, COUNT_DEC, BUF_PTR_CLR, CTRL_WE;
  logic [7:0]  CTRL_ADDR;
  logic [15:0] CTRL_WDATA;
  wire  [3:0]  ADDR, HEAD_NUM;
  wire         LOW_BYTE_ENABLE_N, HIGH_BYTE_ENABLE_N, RD_N, WR_N, IO_CYCLE, D_OE;
  wire         LBA_MODE, DRIVE_SEL, STATUS_ERR;
  wire  [15:0] D_IN, D_OUT, CTRL_RDATA;
  wire  [7:0]  FEATURE, FAILURE_CAUSE;
  wire  [8:0]  SECTORS_REQ;
  wire  [27:0] LBA_ADDR;
  int          n_mismatch, total_checks, ptr, ph;
  logic [31:0] lf;
  logic [15:0] bm [256];
  logic [7:0]  tf [16] = '{default: 8'h00};
  logic [7:0]  codes [6] = '{8'h80, 8'h40, 8'h10, 8'h04, 8'h01, 8'hD5};
  logic [3:0]  ra [9] = '{4'h0, 4'h1, 4'h9, 4'h8, 4'h0, 4'h0, 4'h8, 4'h9, 4'h8};
  logic [3:0]  wa [5] = '{4'h0, 4'h8, 4'h9, 4'h0, 4'h9};
  logic [7:0]  lat;
  logic [15:0] rd, ex;

  ata_task_file_registers #(.BUF_AW(8)) dut_u (.CLK, .ARST_N, .ADDR, .LOW_BYTE_ENABLE_N,
    .HIGH_BYTE_ENABLE_N, .RD_N, .WR_N, .IO_CYCLE, .D_IN, .D_OUT, .D_OE, .IO_WIDE_INDICATE_N,
    .IDE_MODE, .SOCKET_MODE, .COPY_DRIVE, .CMD_START, .ERR_LOAD, .ERR_BAD_BLOCK,
    .ERR_UNCORRECTABLE, .ERR_ID_MISSING, .ERR_ABORTED, .ERR_GENERAL, .COUNT_DEC, .BUF_PTR_CLR,
    .CTRL_WE, .CTRL_ADDR, .CTRL_WDATA, .CTRL_RDATA, .FEATURE, .FAILURE_CAUSE, .SECTORS_REQ,
    .LBA_MODE, .LBA_ADDR, .HEAD_NUM, .DRIVE_SEL, .STATUS_ERR);
  ata_host_model host_u (.CLK, .D_OUT, .ADDR, .LOW_BYTE_ENABLE_N, .HIGH_BYTE_ENABLE_N,
    .RD_N, .WR_N, .IO_CYCLE, .D_IN);

  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  function automatic logic [15:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf[15:0];
  endfunction

  task automatic cmp_rd(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t read got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_out(input logic [27:0] got, input logic [27:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t port got %h exp %h", $time, got, exp);
    end
  endtask

  // Lanes not enabled are masked, the bus gives no promise for them
  task automatic bus(input bit wr, input logic [3:0] a, input logic le, input logic he,
                     input logic [15:0] wd);
    host_u.acc(wr, a, le, he, wd, rd);
    rd = rd & {he ? 8'h00 : 8'hFF, le ? 8'h00 : 8'hFF};
  endtask

  task automatic pulse(ref logic s);
    @(posedge CLK);
    #2 s = 1'b1;
    @(posedge CLK);
    #2 s = 1'b0;
    repeat (3) @(posedge CLK);
    #2;
  endtask

  // Buffer model: word, even-then-odd byte pairs, lone odd bytes
  task automatic mdl(input bit wr, input logic [3:0] a, input logic le, input logic he,
                     input logic [15:0] wd);
    logic [7:0] b;
    b = le ? wd[15:8] : wd[7:0];
    ex = 16'h0000;
    if (!le && !he) begin
      if (wr) bm[ptr] = wd;
      else ex = bm[ptr];
      ptr++;
    end else if (!le && a != 4'h9 && ph == 0) begin
      if (wr) lat = b;
      else ex[7:0] = bm[ptr][7:0];
      ph = 1;
    end else begin
      if (wr) bm[ptr] = {b, lat};
      else if (le) ex[15:8] = bm[ptr][15:8];
      else ex[7:0] = bm[ptr][15:8];
      ptr++;
      ph = 0;
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Watchdog, several times the expected run
  initial begin
    #(50 * 8000);
    n_mismatch++;
    close_out();
  end

  initial begin
    int k, o, i;
    logic [7:0] v;
    {ARST_N, IO_WIDE_INDICATE_N, IDE_MODE, SOCKET_MODE, COPY_DRIVE, CMD_START} = 6'h00;
    {ERR_LOAD, ERR_BAD_BLOCK, ERR_UNCORRECTABLE, ERR_ID_MISSING, ERR_ABORTED} = 5'h00;
    {ERR_GENERAL, COUNT_DEC, BUF_PTR_CLR, CTRL_WE, CTRL_ADDR, CTRL_WDATA} = 28'h0000000;
    {n_mismatch, total_checks, lf} = {32'h0, 32'h0, 32'h9E6757D7};
    tf[6] = 8'hA0;
    repeat (4) @(posedge CLK);
    #2 ARST_N = 1'b1;
    repeat (3) @(posedge CLK);
    #2 cmp_out(28'(SECTORS_REQ), 28'h100);
    cmp_out(28'(FEATURE), 28'h0);
    bus(0, 4'h6, 0, 1, 16'h0000);
    cmp_rd(rd, 16'h00A0);
    bus(0, 4'h7, 0, 1, 16'h0000);
    cmp_rd(rd, 16'h0000);
    $display("test reset done");
    // Odd registers go in on the high lane at the even address below
    for (k = 0; k < 2; k++) begin
      for (o = 2; o < 7; o++) begin
        v = (o == 2 && k == 1) ? 8'h00 : 8'(rnd());
        if (o == 6) v = k ? tf[6] ^ 8'h40 : v | 8'h40;
        tf[o] = (o == 6) ? v | 8'hA0 : v;
        if (o % 2) bus(1, 4'(o - 1), 1, 0, {v, 8'h00});
        else bus(1, 4'(o), 0, 1, {8'h00, v});
      end
      for (o = 2; o < 7; o++) begin
        bus(0, 4'(o), 0, 1, 16'h0000);
        cmp_rd(rd, {8'h00, tf[o]});
      end
      cmp_out(28'(SECTORS_REQ), tf[2] == 8'h00 ? 28'h100 : 28'(tf[2]));
      cmp_out(28'(LBA_MODE), 28'(tf[6][6]));
      cmp_out(28'(DRIVE_SEL), 28'(tf[6][4]));
      if (tf[6][6]) cmp_out(LBA_ADDR, {tf[6][3:0], tf[5], tf[4], tf[3]});
      else cmp_out(28'(HEAD_NUM), 28'(tf[6][3:0]));
    end
    bus(0, 4'h2, 1, 0, 16'h0000);
    cmp_rd(rd, {tf[3], 8'h00});
    host_u.io_sel = 1'b1;
    IO_WIDE_INDICATE_N = 1'b1;
    bus(0, 4'h2, 1, 0, 16'h0000);
    cmp_rd(rd, 16'h0000);
    host_u.io_sel = 1'b0;
    IO_WIDE_INDICATE_N = 1'b0;
    SOCKET_MODE = 1'b1;
    COPY_DRIVE = ~tf[6][4];
    repeat (4) @(posedge CLK);
    #2 cmp_out(28'(DRIVE_SEL), {27'h0, ~tf[6][4]});
    SOCKET_MODE = 1'b0;
    $display("test address registers done");
    for (k = 0; k < 6; k++) begin
      pulse(CMD_START);
      cmp_out(28'(STATUS_ERR), 28'h0);
      v = codes[k];
      {ERR_BAD_BLOCK, ERR_UNCORRECTABLE, ERR_ID_MISSING, ERR_ABORTED, ERR_GENERAL} =
        {v[7], v[6], v[4], v[2], v[0]};
      pulse(ERR_LOAD);
      cmp_out(28'(STATUS_ERR), 28'h1);
      bus(0, 4'h1, 0, 1, 16'h0000);
      cmp_rd(rd, {8'h00, v});
      bus(0, 4'hD, 0, 1, 16'h0000);
      cmp_rd(rd, {8'h00, v});
      bus(0, 4'h0, 1, 0, 16'h0000);
      cmp_rd(rd, {v, 8'h00});
      lat = 8'(rnd());
      bus(1, 4'h1, 0, 1, {8'h00, lat});
      cmp_out(28'(FEATURE), 28'(lat));
      bus(0, 4'h1, 0, 1, 16'h0000);
      cmp_rd(rd, {8'h00, v});
    end
    bus(1, 4'hD, 0, 1, {8'h00, v});
    cmp_out(28'(FEATURE), 28'(v));
    bus(1, 4'h0, 1, 0, {~v, 8'h00});
    cmp_out(28'(FEATURE), {20'h0, ~v});
    IDE_MODE = 1'b1;
    bus(1, 4'h0, 1, 0, {v, 8'h00});
    cmp_out(28'(FEATURE), {20'h0, ~v});
    IDE_MODE = 1'b0;
    $display("test failure and feature done");
    bus(1, 4'h2, 0, 1, 16'h0003);
    for (k = 3; k >= 0; k--) begin
      cmp_out(28'(SECTORS_REQ), k ? 28'(k) : 28'h100);
      pulse(COUNT_DEC);
    end
    bus(0, 4'h2, 0, 1, 16'h0000);
    cmp_rd(rd, 16'h0000);
    $display("test count done");
    // Controller fills the buffer one word per cycle
    for (i = 0; i < 9; i++) begin
      bm[i] = rnd();
      @(posedge CLK);
      #2 {CTRL_WE, CTRL_ADDR, CTRL_WDATA} = {1'b1, 8'(i), bm[i]};
    end
    @(posedge CLK);
    #2 CTRL_WE = 1'b0;
    pulse(BUF_PTR_CLR);
    {ptr, ph} = {32'h0, 32'h0};
    for (i = 0; i < 9; i++) begin
      bus(0, ra[i], i == 8, i > 3 && i < 8, 16'h0000);
      mdl(0, ra[i], i == 8, i > 3 && i < 8, 16'h0000);
      cmp_rd(rd, ex);
    end
    pulse(BUF_PTR_CLR);
    {ptr, ph} = {32'h0, 32'h0};
    for (i = 0; i < 5; i++) begin
      CTRL_WDATA = rnd();
      bus(1, wa[i], i == 4, i > 0 && i < 4, CTRL_WDATA);
      mdl(1, wa[i], i == 4, i > 0 && i < 4, CTRL_WDATA);
    end
    for (i = 0; i < 3; i++) begin
      @(posedge CLK);
      #2 CTRL_ADDR = 8'(i);
      repeat (2) @(posedge CLK);
      cmp_rd(CTRL_RDATA, bm[i]);
    end
    $display("test data port done");
    close_out();
  end
endmodule

bind ata_task_file_registers ata_tf_regs_sva chk_u (.CLK, .ARST_N, .RD_N, .D_OE, .SOCKET_MODE,
  .COPY_DRIVE, .DRIVE_SEL, .CMD_START, .ERR_LOAD, .ERR_BAD_BLOCK, .ERR_UNCORRECTABLE,
  .ERR_ID_MISSING, .ERR_ABORTED, .ERR_GENERAL, .FAILURE_CAUSE, .SECTORS_REQ, .STATUS_ERR);
